/* eep_map.svh */
// Purpose: numeric map of the serial eeprom command and protection block
// Assumes: included by the package and by every design file that needs a figure
// Notes: definitions only
`ifndef EEP_MAP_SVH
`define EEP_MAP_SVH
// ==========================================================================
// opcode fields, bit 3 is ignored
`define OPC_UPPER 4'h0
`define OPC_SET_WL 3'h6
`define OPC_CLR_WL 3'h4
`define OPC_SR_RD 3'h5
`define OPC_SR_WR 3'h1
`define OPC_RD 3'h3
`define OPC_WR 3'h2
// ==========================================================================
// status byte layout
`define ST_PPE 7
`define ST_BG_HI 3
`define ST_BG_LO 2
`define ST_ALL_BUSY 8'hFF
`define ST_GAP 3'h0
`define NV_ERASED 3'h0
// ==========================================================================
// array geometry and guarded ranges
`define ADDR_W 12
`define PAGE_W 5
`define PAGE_BYTES 32
`define BG_QTR_BASE 12'hC00
`define BG_HALF_BASE 12'h800
// ==========================================================================
// timing and pin sync idle levels (cs_n, wp_n, frame toggle)
`define T_WC_US 5000
`define MCLK_MHZ 40
`define SYNC_IDLE 3'h6
`endif

/* eep_pkg.sv */
// Purpose: shared types and decode helpers
// Assumes: eep_map.svh holds every figure
// Notes: functions used by both clock domains
`include "eep_map.svh"
package eep_pkg;
  typedef enum logic [2:0] {
    CMD_NONE, CMD_SET_WL, CMD_CLR_WL, CMD_SR_RD, CMD_SR_WR, CMD_RD, CMD_WR
  } cmd_t;
  typedef enum logic [1:0] {
    PH_OPC = 2'h0, PH_ADR = 2'h1, PH_DAT = 2'h3, PH_IGN = 2'h2
  } link_ph_t;
  typedef enum logic [1:0] {
    WC_IDLE = 2'h0, WC_PROG = 2'h1, WC_WAIT = 2'h3
  } wc_st_t;

  // ========================================================================
  // opcode decode, upper nibble zero and bit 3 ignored
  function automatic cmd_t decode_cmd(input logic [7:0] op);
    cmd_t c;
    c = CMD_NONE;
    if (op[7:4] == `OPC_UPPER) begin
      case (op[2:0])
        `OPC_SET_WL: c = CMD_SET_WL;
        `OPC_CLR_WL: c = CMD_CLR_WL;
        `OPC_SR_RD: c = CMD_SR_RD;
        `OPC_SR_WR: c = CMD_SR_WR;
        `OPC_RD: c = CMD_RD;
        `OPC_WR: c = CMD_WR;
        default: c = CMD_NONE;
      endcase
    end
    return c;
  endfunction : decode_cmd

  // ========================================================================
  // block guard range check
  function automatic logic is_guarded(input logic [`ADDR_W-1:0] a, input logic [1:0] bg);
    logic g;
    g = 1'b0;
    case (bg)
      2'h1: g = (a >= `BG_QTR_BASE);
      2'h2: g = (a >= `BG_HALF_BASE);
      2'h3: g = 1'b1;
      default: g = 1'b0;
    endcase
    return g;
  endfunction : is_guarded
endpackage : eep_pkg

/* pin_sync.sv */
// Purpose: three-stage synchroniser with agreement filter
// Assumes: inputs come from another clock domain or a pin
// Notes: output follows once stages two and three agree
`include "eep_map.svh"
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1_ff, s2_ff, s3_ff, q_ff;
  logic [W-1:0] nxt_q;

  if (W < 1) begin : g_chk
    $error("pin_sync width must be at least one");
  end

  // ========================================================================
  // take a bit over only when the last two stages agree
  always_comb begin
    nxt_q = q_ff;
    for (int i = 0; i < W; i++) begin
      if (s2_ff[i] == s3_ff[i]) nxt_q[i] = s3_ff[i];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s1_ff <= INIT;
      s2_ff <= INIT;
      s3_ff <= INIT;
      q_ff <= INIT;
    end else begin
      s1_ff <= d_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      q_ff <= nxt_q;
    end
  end

  assign q_o = q_ff;
endmodule : pin_sync

/* spi_link.sv */
// Purpose: serial-clock side of the eeprom, shifts commands in and data out
// Assumes: mode 0, sck still outside frames, cs_n high ends every frame
// Notes: frame registers stay still after cs_n rises for the mclk side
`include "eep_map.svh"
module spi_link #(
  parameter int PAGE_BYTES = `PAGE_BYTES
) (
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  input wire logic [7:0] status_i,
  input wire logic [7:0] rd_byte_i,
  input wire logic [`PAGE_W-1:0] buf_idx_i,
  output logic [`ADDR_W-1:0] rd_addr_o,
  output eep_pkg::cmd_t cmd_o,
  output logic [15:0] adr_o,
  output logic frame_ok_o,
  output logic frame_tgl_o,
  output logic [7:0] sr_byte_o,
  output logic [7:0] buf_byte_o,
  output logic [PAGE_BYTES-1:0] buf_vld_o,
  output logic so_o,
  output logic so_oe_n_o
);
  logic fresh_ff, tgl_ff = 1'b0, ab_ff, ab_c, got_ff, buf_we, busy_s, drive;
  logic [7:0] st1_ff, st2_ff, op_ff, sr_ff, byte_c, rd_out;
  logic [6:0] shift_ff;
  logic [2:0] bits_ff, bits_c;
  logic [15:0] adr_ff;
  logic [`ADDR_W-1:0] rda_ff;
  logic [`PAGE_W-1:0] wp_ff;
  logic [PAGE_BYTES-1:0] vld_ff;
  logic [7:0] pbuf [PAGE_BYTES];
  eep_pkg::link_ph_t ph_ff, ph_c, nxt_ph;
  eep_pkg::cmd_t cur_cmd, new_cmd;
  logic nxt_tgl, nxt_ab, nxt_got, so_ff, oe_n_ff, nxt_so, nxt_oe_n;
  logic [7:0] nxt_op, nxt_sr;
  logic [6:0] nxt_shift;
  logic [2:0] nxt_bits;
  logic [15:0] nxt_adr;
  logic [`ADDR_W-1:0] nxt_rda;
  logic [`PAGE_W-1:0] nxt_wp;
  logic [PAGE_BYTES-1:0] nxt_vld;

  if (PAGE_BYTES != (1 << `PAGE_W)) begin : g_chk
    $error("page size must match the page index width");
  end

  // ========================================================================
  // status into the sck domain, two flops
  always_ff @(posedge sck_i) begin
    st1_ff <= status_i;
    st2_ff <= st1_ff;
  end
  assign busy_s = st2_ff[0];

  // frame start marker, set by cs_n itself
  always_ff @(posedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) fresh_ff <= 1'b1;
    else fresh_ff <= 1'b0;
  end

  // ========================================================================
  // input shifting and command sequencing, msb first on rising sck
  always_comb begin
    ph_c = fresh_ff ? eep_pkg::PH_OPC : ph_ff;
    bits_c = fresh_ff ? 3'h0 : bits_ff;
    ab_c = fresh_ff ? 1'b0 : ab_ff;
    byte_c = {shift_ff, si_i};
    cur_cmd = eep_pkg::decode_cmd(op_ff);
    new_cmd = eep_pkg::decode_cmd(byte_c);
    nxt_ph = ph_c;
    nxt_bits = bits_c + 3'h1;
    nxt_shift = byte_c[6:0];
    nxt_op = op_ff;
    nxt_adr = adr_ff;
    nxt_rda = rda_ff;
    nxt_wp = wp_ff;
    nxt_vld = (fresh_ff && !busy_s) ? '0 : vld_ff;
    nxt_got = fresh_ff ? 1'b0 : got_ff;
    nxt_sr = sr_ff;
    nxt_ab = ab_c;
    nxt_tgl = tgl_ff ^ fresh_ff;
    buf_we = 1'b0;
    if (bits_c == 3'h7) begin
      unique case (ph_c)
        eep_pkg::PH_OPC: begin
          nxt_op = byte_c;
          if (busy_s && new_cmd != eep_pkg::CMD_SR_RD) nxt_ph = eep_pkg::PH_IGN;
          else if (new_cmd == eep_pkg::CMD_RD || new_cmd == eep_pkg::CMD_WR)
            nxt_ph = eep_pkg::PH_ADR;
          else if (new_cmd == eep_pkg::CMD_SR_RD || new_cmd == eep_pkg::CMD_SR_WR)
            nxt_ph = eep_pkg::PH_DAT;
          else nxt_ph = eep_pkg::PH_IGN;
        end
        eep_pkg::PH_ADR: begin
          nxt_adr = {adr_ff[7:0], byte_c};
          nxt_ab = 1'b1;
          if (ab_c) begin
            nxt_ph = eep_pkg::PH_DAT;
            nxt_rda = {adr_ff[3:0], byte_c};
            nxt_wp = byte_c[`PAGE_W-1:0];
          end
        end
        eep_pkg::PH_DAT: begin
          nxt_got = 1'b1;
          if (cur_cmd == eep_pkg::CMD_WR) begin
            buf_we = 1'b1;
            nxt_vld[wp_ff] = 1'b1;
            nxt_wp = wp_ff + 5'h01;
          end
          if (cur_cmd == eep_pkg::CMD_SR_WR && !got_ff) nxt_sr = byte_c;
          if (cur_cmd == eep_pkg::CMD_RD) nxt_rda = rda_ff + 12'h001;
        end
        eep_pkg::PH_IGN: nxt_ph = eep_pkg::PH_IGN;
      endcase
    end
  end

  always_ff @(posedge sck_i) begin
    ph_ff <= nxt_ph;
    bits_ff <= nxt_bits;
    shift_ff <= nxt_shift;
    op_ff <= nxt_op;
    adr_ff <= nxt_adr;
    rda_ff <= nxt_rda;
    wp_ff <= nxt_wp;
    vld_ff <= nxt_vld;
    got_ff <= nxt_got;
    sr_ff <= nxt_sr;
    ab_ff <= nxt_ab;
    tgl_ff <= nxt_tgl;
    if (buf_we) pbuf[wp_ff] <= byte_c;
  end

  // ========================================================================
  // serial output, msb first, changed on falling sck
  always_comb begin
    rd_out = (cur_cmd == eep_pkg::CMD_RD) ? rd_byte_i : st2_ff;
    drive = !fresh_ff && ph_ff == eep_pkg::PH_DAT &&
      (cur_cmd == eep_pkg::CMD_RD || cur_cmd == eep_pkg::CMD_SR_RD);
    nxt_so = rd_out[3'h7 - bits_ff];
    nxt_oe_n = !drive;
  end

  always_ff @(negedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      so_ff <= 1'b0;
      oe_n_ff <= 1'b1;
    end else begin
      so_ff <= nxt_so;
      oe_n_ff <= nxt_oe_n;
    end
  end

  assign so_o = so_ff;
  assign so_oe_n_o = oe_n_ff;
  assign rd_addr_o = rda_ff;
  assign cmd_o = cur_cmd;
  assign adr_o = adr_ff;
  assign frame_ok_o = ph_ff == eep_pkg::PH_DAT && bits_ff == 3'h0 && got_ff;
  assign frame_tgl_o = tgl_ff;
  assign sr_byte_o = sr_ff;
  assign buf_byte_o = pbuf[buf_idx_i];
  assign buf_vld_o = vld_ff;
endmodule : spi_link

/* eep_cmd_protect.sv */
// Purpose: command, latch, status and protection core of a 4096-byte eeprom
// Assumes: serial side in spi_link, pins cross via pin_sync
// Notes: guard bits and array keep their contents without reset
`include "eep_map.svh"
module eep_cmd_protect #(
  parameter int WC_CYCLES = `T_WC_US * `MCLK_MHZ
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  input wire logic wp_n_i,
  output logic so_o,
  output logic so_oe_n_o,
  output logic busy_o
);
  localparam int CNT_W = $clog2(WC_CYCLES);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(WC_CYCLES - 1);

  if (WC_CYCLES < 2 * `PAGE_BYTES) begin : g_chk
    $error("write cycle too short to program a page");
  end

  // link results and synchronised pins
  logic [`ADDR_W-1:0] rd_addr;
  eep_pkg::cmd_t lk_cmd;
  logic [15:0] lk_adr;
  logic lk_ok, lk_tgl;
  logic [7:0] lk_sr, lk_buf;
  logic [`PAGE_BYTES-1:0] lk_vld;
  logic [2:0] sy;
  logic cs_q, wp_q, tgl_q;

  // core state
  logic [7:0] mem [1 << `ADDR_W];
  logic [2:0] nv_ff = `NV_ERASED;
  logic wel_ff, cs_prev_ff, seen_ff, busy_ff;
  logic [7:0] status_ff;
  eep_pkg::wc_st_t st_ff, nxt_st;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [`PAGE_W-1:0] k_ff, nxt_k;
  logic [`ADDR_W-`PAGE_W-1:0] page_ff, nxt_page;
  logic [`PAGE_BYTES-1:0] vldc_ff, nxt_vldc;
  logic [2:0] nxt_nv;
  logic nxt_wel, nxt_seen, nxt_busy;
  logic [7:0] nxt_status;
  logic frame_go, hwp, mem_we, cycle_end;
  logic [`ADDR_W-1:0] mem_wa;

  // ========================================================================
  // serial front end in the sck domain
  spi_link #(
    .PAGE_BYTES(`PAGE_BYTES)
  ) u_link (
    .sck_i(sck_i),
    .cs_n_i(cs_n_i),
    .si_i(si_i),
    .status_i(status_ff),
    .rd_byte_i(mem[rd_addr]),
    .buf_idx_i(k_ff),
    .rd_addr_o(rd_addr),
    .cmd_o(lk_cmd),
    .adr_o(lk_adr),
    .frame_ok_o(lk_ok),
    .frame_tgl_o(lk_tgl),
    .sr_byte_o(lk_sr),
    .buf_byte_o(lk_buf),
    .buf_vld_o(lk_vld),
    .so_o(so_o),
    .so_oe_n_o(so_oe_n_o)
  );

  // ========================================================================
  // chip select, guard pin and frame toggle into mclk
  pin_sync #(
    .W(3),
    .INIT(`SYNC_IDLE)
  ) u_sync (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .d_i({cs_n_i, wp_n_i, lk_tgl}),
    .q_o(sy)
  );

  assign cs_q = sy[2];
  assign wp_q = sy[1];
  assign tgl_q = sy[0];

  // ========================================================================
  // frame end detection and protection state
  always_comb begin
    frame_go = cs_q && !cs_prev_ff && (tgl_q != seen_ff);
    hwp = !wp_q && nv_ff[2];
    cycle_end = st_ff == eep_pkg::WC_WAIT && cnt_ff == CNT_LAST;
    mem_wa = {page_ff, k_ff};
    mem_we = st_ff == eep_pkg::WC_PROG && vldc_ff[k_ff] &&
      !eep_pkg::is_guarded(mem_wa, nv_ff[1:0]);
  end

  // ========================================================================
  // command execution and self-timed write cycle
  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_k = k_ff;
    nxt_page = page_ff;
    nxt_vldc = vldc_ff;
    nxt_nv = nv_ff;
    nxt_wel = wel_ff;
    nxt_seen = frame_go ? tgl_q : seen_ff;
    unique case (st_ff)
      eep_pkg::WC_IDLE: begin
        if (frame_go) begin
          unique case (lk_cmd)
            eep_pkg::CMD_SET_WL: nxt_wel = 1'b1;
            eep_pkg::CMD_CLR_WL: nxt_wel = 1'b0;
            eep_pkg::CMD_WR: begin
              if (wel_ff && lk_ok) begin
                nxt_st = eep_pkg::WC_PROG;
                nxt_page = lk_adr[`ADDR_W-1:`PAGE_W];
                nxt_vldc = lk_vld;
                nxt_k = '0;
                nxt_cnt = '0;
              end
            end
            eep_pkg::CMD_SR_WR: begin
              if (wel_ff && lk_ok && !hwp) begin
                nxt_nv = {lk_sr[`ST_PPE], lk_sr[`ST_BG_HI], lk_sr[`ST_BG_LO]};
                nxt_st = eep_pkg::WC_PROG;
                nxt_vldc = '0;
                nxt_k = '0;
                nxt_cnt = '0;
              end
            end
            default: nxt_st = eep_pkg::WC_IDLE;
          endcase
        end
      end
      eep_pkg::WC_PROG: begin
        nxt_cnt = cnt_ff + CNT_W'(1);
        nxt_k = k_ff + 5'h01;
        if (k_ff == 5'h1F) nxt_st = eep_pkg::WC_WAIT;
      end
      eep_pkg::WC_WAIT: begin
        nxt_cnt = cnt_ff + CNT_W'(1);
        if (cycle_end) begin
          nxt_st = eep_pkg::WC_IDLE;
          nxt_wel = 1'b0;
        end
      end
      default: nxt_st = eep_pkg::WC_IDLE;
    endcase
    nxt_busy = nxt_st != eep_pkg::WC_IDLE;
    nxt_status = nxt_busy ? `ST_ALL_BUSY :
      {nxt_nv[2], `ST_GAP, nxt_nv[1:0], nxt_wel, 1'b0};
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st_ff <= eep_pkg::WC_IDLE;
      cnt_ff <= '0;
      k_ff <= '0;
      page_ff <= '0;
      vldc_ff <= '0;
      wel_ff <= 1'b0;
      cs_prev_ff <= 1'b1;
      seen_ff <= 1'b0;
      busy_ff <= 1'b0;
      status_ff <= {nv_ff[2], `ST_GAP, nv_ff[1:0], 2'h0};
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      k_ff <= nxt_k;
      page_ff <= nxt_page;
      vldc_ff <= nxt_vldc;
      wel_ff <= nxt_wel;
      cs_prev_ff <= cs_q;
      seen_ff <= nxt_seen;
      busy_ff <= nxt_busy;
      status_ff <= nxt_status;
    end
  end

  // nonvolatile cells, untouched by reset
  always_ff @(posedge mclk_i) begin
    if (!rst_i) nv_ff <= nxt_nv;
    if (mem_we) mem[mem_wa] <= lk_buf;
  end

  assign busy_o = busy_ff;

  // ========================================================================
  // checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  sequence s_frame_end;
    frame_go && st_ff == eep_pkg::WC_IDLE;
  endsequence
  sequence s_cycle_last;
    st_ff == eep_pkg::WC_WAIT && cnt_ff == CNT_LAST;
  endsequence

  a_reset_latch_low: assert property ($fell(rst_i) |-> !wel_ff)
    else $error("write latch not clear after reset");
  a_prog_needs_latch: assert property ($rose(busy_o) |-> $past(wel_ff))
    else $error("write cycle started without write latch");
  a_clear_latch_cmd: assert property (s_frame_end ##0 lk_cmd == eep_pkg::CMD_CLR_WL
    |=> !wel_ff && !busy_o)
    else $error("clear-latch command did not clear");
  a_busy_all_ones: assert property (busy_o |-> status_ff == `ST_ALL_BUSY)
    else $error("status not all ones while busy");
  a_idle_status_bits: assert property (!busy_o |-> !status_ff[0] &&
    status_ff[6:4] == `ST_GAP && status_ff[1] == wel_ff)
    else $error("idle status bits wrong");
  a_guard_no_write: assert property (mem_we |->
    !eep_pkg::is_guarded(mem_wa, nv_ff[1:0]) && mem_wa[11:5] == page_ff)
    else $error("guarded or off-page byte programmed");
  a_hw_reject_sr: assert property (s_frame_end ##0 lk_cmd == eep_pkg::CMD_SR_WR && hwp
    |=> $stable(nv_ff) && !busy_o)
    else $error("status write accepted under hardware protection");
  a_cycle_end_latch: assert property (s_cycle_last |=> !wel_ff && !busy_o ##1 !busy_o)
    else $error("write latch not cleared at cycle end");
  a_busy_ignore_cmd: assert property (frame_go && busy_o && !cycle_end
    |=> $stable(nv_ff) && $stable(wel_ff))
    else $error("command acted on during write cycle");
  a_cycle_length: assert property ($rose(busy_o) |-> busy_o [*8])
    else $error("write cycle ended too early");

  // ========================================================================
  // protection checks on the nonvolatile bits

  // a frame of the given kind has just ended while idle
  sequence s_status_write_end;
    s_frame_end ##0 lk_cmd == eep_pkg::CMD_SR_WR;
  endsequence
  sequence s_status_write_taken;
    s_status_write_end ##0 wel_ff && lk_ok && !hwp;
  endsequence
  sequence s_program_end;
    s_frame_end ##0 (lk_cmd == eep_pkg::CMD_WR || lk_cmd == eep_pkg::CMD_SR_WR);
  endsequence

  // pin protect enable must not drop while the guard pin is held low
  a_ppe_held_low: assert property (!wp_q && nv_ff[2] |=> nv_ff[2])
    else $error("pin protect enable cleared while pin low");

  // accepted status write takes bit 7 and bits 3..2 only
  a_status_fields: assert property (s_status_write_taken |=>
    nv_ff[2] == lk_sr[`ST_PPE] && nv_ff[1] == lk_sr[`ST_BG_HI] &&
    nv_ff[0] == lk_sr[`ST_BG_LO])
    else $error("status write took the wrong bits");

  // a programming frame without the latch leaves everything alone
  a_no_latch_drop: assert property (s_program_end ##0 !wel_ff
    |=> !busy_o && $stable(nv_ff))
    else $error("programming frame acted without write latch");

  // ========================================================================
  // latch and write-cycle sequencing checks

  // the set-latch command raises status bit 1 when idle
  a_set_latch_cmd: assert property (s_frame_end ##0 lk_cmd == eep_pkg::CMD_SET_WL
    |=> wel_ff && status_ff[1])
    else $error("set-latch command did not set the latch");

  // page programming walks all 32 slots, then waits out the cycle
  a_page_walk_end: assert property (st_ff == eep_pkg::WC_PROG && k_ff == 5'h1F
    |=> st_ff == eep_pkg::WC_WAIT && k_ff == 5'h00)
    else $error("page walk did not end after the last slot");

  // busy flag in the status byte follows the cycle state
  a_busy_bit_zero: assert property (busy_o |-> status_ff[0])
    else $error("busy bit low during write cycle");

  // a running cycle cannot start again from an incoming frame
  a_cycle_no_restart: assert property (st_ff == eep_pkg::WC_WAIT && !cycle_end
    |=> st_ff == eep_pkg::WC_WAIT)
    else $error("write cycle left its wait early");
endmodule : eep_cmd_protect

/* spi_master.sv */
// Purpose: serial bus master model driving the eeprom block
// Assumes: mode 0, sck still between frames, 15 ns sck period
// Notes: so line has a pull-up, so a released line reads 1
module spi_master (
  output logic sck_o,
  output logic cs_n_o,
  output logic si_o,
  input wire logic so_i,
  input wire logic so_oe_n_i
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================================
  // frame buffers and line state
  logic [7:0] txb [0:39];
  logic [7:0] rxb [0:39];
  logic drove;
  wire so_w = so_oe_n_i ? 1'b1 : so_i; // pull-up when released
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
    drove = 1'b0;
  end
  // ==========================================================================
  // one frame of n bytes, msb first, sck low outside the frame
  task automatic xfer(input int n);
    drove = 1'b0;
    cs_n_o = 1'b0;
    #7.5;
    for (int j = 0; j < n; j++) begin
      for (int i = 7; i >= 0; i--) begin
        si_o = txb[j][i];
        #7.5;
        rxb[j][i] = so_w;
        drove = drove | ~so_oe_n_i;
        sck_o = 1'b1;
        #7.5;
        sck_o = 1'b0;
      end
    end
    #3;
    cs_n_o = 1'b1;
    si_o = ~si_o;
    #300;
  endtask : xfer
endmodule : spi_master

/* testbench.sv */
// Purpose: self-checking bench for the eeprom command and protection core
// Assumes: short write cycle of 100 mclk cycles
// Notes: array starts unknown, so every address is written before it is read
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin num_errors++; \
  $display("unexpected at %0t: got %h want %h", $time, a, e); end end
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================================
  // clock, pins and counters
  logic mclk = 1'b0;
  logic rst, wp_n, sck, cs_n, si, so, so_oe_n, busy, was_busy;
  logic [7:0] st;
  int num_errors = 0;
  int checked = 0;
  always #12.5 mclk = ~mclk;
  eep_cmd_protect #(.WC_CYCLES(100)) dut (.mclk_i(mclk), .rst_i(rst), .sck_i(sck),
    .cs_n_i(cs_n), .si_i(si), .wp_n_i(wp_n), .so_o(so), .so_oe_n_o(so_oe_n), .busy_o(busy));
  spi_master master (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .so_i(so), .so_oe_n_i(so_oe_n));
  // ==========================================================================
  // verdict and shared frame tasks
  task automatic test_done;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done
  task automatic cmd1(input logic [7:0] op);
    master.txb[0] = op;
    master.xfer(1);
  endtask : cmd1
  task automatic sr;
    master.txb[0] = 8'h05;
    master.xfer(2);
    st = master.rxb[1];
  endtask : sr
  // wait out a write cycle, noting whether one started
  task automatic settle;
    int k;
    was_busy = 1'b0;
    repeat (12) begin
      @(posedge mclk);
      was_busy = was_busy | busy;
    end
    k = 0;
    while (busy !== 1'b0 && k < 400) begin
      @(posedge mclk);
      k++;
    end
    `CHK(busy, 1'b0)
  endtask : settle
  // upper address nibble set to junk, it must not matter
  task automatic wr(input bit en, input logic [11:0] a, input int n, input logic [7:0] d);
    if (en) cmd1(8'h0E);
    master.txb[0] = 8'h0A;
    master.txb[1] = {4'hF, a[11:8]};
    master.txb[2] = a[7:0];
    for (int k = 0; k < n; k++) master.txb[3 + k] = d + 8'(k);
    master.xfer(n + 3);
  endtask : wr
  task automatic rd(input logic [11:0] a, input int n);
    master.txb[0] = 8'h0B;
    master.txb[1] = {4'hA, a[11:8]};
    master.txb[2] = a[7:0];
    master.xfer(n + 3);
  endtask : rd
  task automatic sw(input logic [7:0] v);
    cmd1(8'h06);
    master.txb[0] = 8'h09;
    master.txb[1] = v;
    master.xfer(2);
    settle;
  endtask : sw
  // ==========================================================================
  // scenarios
  task automatic t_latch;
    sr;
    `CHK(st, 8'h00)
    wr(1'b0, 12'h010, 1, 8'h5A);
    settle;
    `CHK(was_busy, 1'b0)
    cmd1(8'h06);
    sr;
    `CHK(st, 8'h02)
    @(posedge mclk);
    wp_n <= 1'b0;
    cmd1(8'h0C);
    sr;
    `CHK(st, 8'h00)
    @(posedge mclk);
    wp_n <= 1'b1;
  endtask : t_latch
  task automatic t_page;
    wr(1'b1, 12'h020, 33, 8'h40);
    sr;
    `CHK(st, 8'hFF)
    rd(12'h020, 1);
    `CHK(master.drove, 1'b0)
    settle;
    `CHK(was_busy, 1'b1)
    sr;
    `CHK(st, 8'h00)
    rd(12'h020, 32);
    for (int k = 0; k < 32; k++) begin
      `CHK(master.rxb[3 + k], (k == 0) ? 8'h60 : 8'(8'h40 + k))
    end
  endtask : t_page
  task automatic t_wrap;
    wr(1'b1, 12'hFFF, 1, 8'hA1);
    settle;
    wr(1'b1, 12'h000, 1, 8'hB2);
    settle;
    rd(12'hFFF, 2);
    `CHK(master.rxb[3], 8'hA1)
    `CHK(master.rxb[4], 8'hB2)
  endtask : t_wrap
  task automatic t_guard;
    logic [11:0] ad [4] = '{12'h7FF, 12'h800, 12'hBFF, 12'hC00};
    logic [7:0] ex [4];
    logic g_hit;
    for (int g = 0; g < 4; g++) begin
      sw({4'h7, 2'(g), 2'h3});
      sr;
      `CHK(st, {4'h0, 2'(g), 2'h0})
      for (int k = 0; k < 4; k++) begin
        wr(1'b1, ad[k], 1, 8'(16 * g + k + 1));
        settle;
        g_hit = (g == 3) || (g == 2 && ad[k] >= 12'h800) || (g == 1 && ad[k] >= 12'hC00);
        if (!g_hit) ex[k] = 8'(16 * g + k + 1);
      end
      for (int k = 0; k < 4; k++) begin
        rd(ad[k], 1);
        `CHK(master.rxb[3], ex[k])
      end
    end
  endtask : t_guard
  task automatic t_hw;
    sw(8'h80);
    @(posedge mclk);
    wp_n <= 1'b0;
    sw(8'h0C);
    `CHK(was_busy, 1'b0)
    sr;
    `CHK(st, 8'h82)
    wr(1'b1, 12'h123, 1, 8'h5C);
    settle;
    rd(12'h123, 1);
    `CHK(master.rxb[3], 8'h5C)
    @(posedge mclk);
    wp_n <= 1'b1;
    sw(8'h00);
    sr;
    `CHK(st, 8'h00)
  endtask : t_hw
  // ==========================================================================
  // main sequence and watchdog
  initial begin
    rst = 1'b1;
    wp_n = 1'b1;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    repeat (8) @(posedge mclk);
    t_latch;
    t_page;
    t_wrap;
    t_guard;
    t_hw;
    test_done;
  end
  initial begin
    #1000000;
    num_errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    test_done;
  end
endmodule : testbench
